// File: temp_alarm_pkg.sv
// constants shared by the temperature limit alarm block
package temp_alarm_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] OFS_REMOTE_TEMP = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_LOCAL_HIGH = 8'h10;
  localparam logic [7:0] OFS_LOCAL_LOW = 8'h14;
  localparam logic [7:0] OFS_REMOTE_HIGH = 8'h18;
  localparam logic [7:0] OFS_REMOTE_LOW = 8'h1c;
  localparam logic [7:0] OFS_LOCAL_CRIT = 8'h20;
  localparam logic [7:0] OFS_REMOTE_CRIT = 8'h24;
  localparam logic [7:0] OFS_CRIT_HYST = 8'h28;
  localparam logic [7:0] OFS_REMOTE_OFFSET = 8'h2c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CFG_MASK_BIT = 7;
  localparam int unsigned CFG_STANDBY_BIT = 6;
  localparam int unsigned ST_ALERT_BIT = 7;
  localparam int unsigned ST_LOC_HIGH_BIT = 6;
  localparam int unsigned ST_LOC_LOW_BIT = 5;
  localparam int unsigned ST_REM_HIGH_BIT = 4;
  localparam int unsigned ST_REM_LOW_BIT = 3;
  localparam int unsigned ST_OPEN_BIT = 2;
  localparam int unsigned ST_REM_CRIT_BIT = 1;
  localparam int unsigned ST_LOC_CRIT_BIT = 0;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [7:0] HIGH_RST = 8'h55;
  localparam logic [7:0] CRIT_RST = 8'h55;
  localparam logic [7:0] HYST_RST = 8'h0a;
  localparam logic [7:0] OFFSET_RST = 8'h00;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] SHORT_CODE = 8'h80;
  localparam logic [7:0] TEMP_MAX = 8'h7f;

endpackage

// File: temp_limit_check.sv
// one channel's limit comparators and critical hysteresis latch
`timescale 1ns/100ps
module temp_limit_check (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // stored reading and limits
  input wire logic signed [7:0] temp_i,
  input wire logic signed [7:0] low_i,
  input wire logic signed [7:0] high_i,
  input wire logic signed [7:0] crit_i,
  input wire logic [7:0] hyst_i,
  // results
  output logic low_hit_o,
  output logic high_hit_o,
  output logic crit_o
);

  typedef struct packed {
    logic crit;
  } chk_state_type;

  chk_state_type q;
  chk_state_type d;
  logic signed [9:0] release_lvl;

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  always_comb begin
    release_lvl = 10'(crit_i) - $signed({2'b00, hyst_i});
    low_hit_o = (temp_i <= low_i);
    high_hit_o = (temp_i > high_i);
    d = q;
    if (temp_i > crit_i) begin
      d.crit = 1'b1;
    end else if (10'(temp_i) <= release_lvl) begin
      d.crit = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign crit_o = q.crit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  crit_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (temp_i > crit_i) |=> crit_o)
    else $error("critical latch did not set above its limit");

  crit_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (crit_o && (10'(temp_i) > release_lvl)) |=> crit_o)
    else $error("critical latch released above limit minus hysteresis");

endmodule // temp_limit_check

// File: temp_limit_alarm.sv
// temperature limit alarm logic with ahb-lite register access
`timescale 1ns/100ps
module temp_limit_alarm (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // measurement front end
  input wire logic CONV_START_I,
  input wire logic CONV_DONE_I,
  input wire logic [7:0] LOCAL_RESULT_I,
  input wire logic [7:0] REMOTE_RESULT_I,
  input wire logic REMOTE_UNDER_I,
  input wire logic REMOTE_OPEN_PIN_I,
  output logic STANDBY_O,
  // alert response handshake from the serial interface
  input wire logic ALERT_ACK_I,
  // open-drain pins
  output logic ALERT_OUT_O,
  output logic ALERT_OE_N_O,
  output logic CRITICAL_OUT_N_O,
  output logic CRITICAL_OE_N_O
);

  typedef struct packed {
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [7:0] loc_temp;
    logic [7:0] rem_temp;
    logic [7:0] cfg;
    logic [7:0] loc_high;
    logic [7:0] loc_low;
    logic [7:0] rem_high;
    logic [7:0] rem_low;
    logic [7:0] loc_crit;
    logic [7:0] rem_crit;
    logic [7:0] hyst;
    logic [7:0] offset;
    logic [2:0] open_sync;
    logic open_filt;
    logic open_flag;
    logic loc_low_hit;
    logic loc_high_hit;
    logic rem_low_hit;
    logic rem_high_hit;
    logic alert_pend;
    logic alert_oe_n;
    logic crit_oe_n;
  } alarm_state_type;

  alarm_state_type q;
  alarm_state_type d;
  logic rst_meta_q;
  logic rst_n;
  logic accept;
  logic [7:0] rd_byte;
  logic signed [8:0] rem_sum;
  logic [7:0] rem_store;
  logic [1:0] low_hit;
  logic [1:0] high_hit;
  logic [1:0] crit_hit;
  logic alert_cond;
  logic [7:0] ch_temp [2];
  logic [7:0] ch_low [2];
  logic [7:0] ch_high [2];
  logic [7:0] ch_crit [2];

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // channel comparators, index 0 local, 1 remote
  // ----------------------------------------------------------------
  assign ch_temp[0] = q.loc_temp;
  assign ch_temp[1] = q.rem_temp;
  assign ch_low[0] = q.loc_low;
  assign ch_low[1] = q.rem_low;
  assign ch_high[0] = q.loc_high;
  assign ch_high[1] = q.rem_high;
  assign ch_crit[0] = q.loc_crit;
  assign ch_crit[1] = q.rem_crit;

  // limits compared continuously, so new readings and new limits both count
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      temp_limit_check u_check (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .temp_i(ch_temp[ch]),
        .low_i(ch_low[ch]),
        .high_i(ch_high[ch]),
        .crit_i(ch_crit[ch]),
        .hyst_i(q.hyst),
        .low_hit_o(low_hit[ch]),
        .high_hit_o(high_hit[ch]),
        .crit_o(crit_hit[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    unique case (q.addr)
      temp_alarm_pkg::OFS_LOCAL_TEMP: rd_byte = q.loc_temp;
      temp_alarm_pkg::OFS_REMOTE_TEMP: rd_byte = q.rem_temp;
      temp_alarm_pkg::OFS_STATUS: rd_byte = {q.alert_pend, q.loc_high_hit, q.loc_low_hit,
                                             q.rem_high_hit, q.rem_low_hit, q.open_flag,
                                             ~q.crit_oe_n & crit_hit[1],
                                             ~q.crit_oe_n & crit_hit[0]};
      temp_alarm_pkg::OFS_CONFIG: rd_byte = q.cfg;
      temp_alarm_pkg::OFS_LOCAL_HIGH: rd_byte = q.loc_high;
      temp_alarm_pkg::OFS_LOCAL_LOW: rd_byte = q.loc_low;
      temp_alarm_pkg::OFS_REMOTE_HIGH: rd_byte = q.rem_high;
      temp_alarm_pkg::OFS_REMOTE_LOW: rd_byte = q.rem_low;
      temp_alarm_pkg::OFS_LOCAL_CRIT: rd_byte = q.loc_crit;
      temp_alarm_pkg::OFS_REMOTE_CRIT: rd_byte = q.rem_crit;
      temp_alarm_pkg::OFS_CRIT_HYST: rd_byte = q.hyst;
      temp_alarm_pkg::OFS_REMOTE_OFFSET: rd_byte = q.offset;
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    accept = HSEL_I & HTRANS_I[1] & HREADY_I;
    rem_sum = 9'($signed(REMOTE_RESULT_I)) + 9'($signed(q.offset));
    if (REMOTE_UNDER_I) begin
      rem_store = temp_alarm_pkg::SHORT_CODE;
    end else if (rem_sum > $signed(9'(temp_alarm_pkg::TEMP_MAX))) begin
      rem_store = temp_alarm_pkg::TEMP_MAX;
    end else if (rem_sum < $signed({1'b1, temp_alarm_pkg::SHORT_CODE})) begin
      rem_store = temp_alarm_pkg::SHORT_CODE;
    end else begin
      rem_store = rem_sum[7:0];
    end
    // bus: writes take no wait state, reads take one
    d.hresp = 1'b0;
    d.wr_pend = accept & HWRITE_I;
    d.rd_pend = accept & ~HWRITE_I;
    if (accept) begin
      d.addr = HADDR_I[7:0];
    end
    if (q.rd_pend) begin
      d.hrdata = {24'h000000, rd_byte};
      d.hready = 1'b1;
    end else begin
      d.hready = ~(accept & ~HWRITE_I);
    end
    if (q.wr_pend) begin
      unique case (q.addr)
        temp_alarm_pkg::OFS_CONFIG: d.cfg = HWDATA_I[7:0];
        temp_alarm_pkg::OFS_LOCAL_HIGH: d.loc_high = HWDATA_I[7:0];
        temp_alarm_pkg::OFS_LOCAL_LOW: d.loc_low = HWDATA_I[7:0];
        temp_alarm_pkg::OFS_REMOTE_HIGH: d.rem_high = HWDATA_I[7:0];
        temp_alarm_pkg::OFS_REMOTE_LOW: d.rem_low = HWDATA_I[7:0];
        temp_alarm_pkg::OFS_LOCAL_CRIT: d.loc_crit = HWDATA_I[7:0];
        temp_alarm_pkg::OFS_REMOTE_CRIT: d.rem_crit = HWDATA_I[7:0];
        temp_alarm_pkg::OFS_CRIT_HYST: d.hyst = HWDATA_I[7:0];
        temp_alarm_pkg::OFS_REMOTE_OFFSET: d.offset = HWDATA_I[7:0];
        default: d.cfg = q.cfg;
      endcase
    end
    // conversion results
    if (CONV_DONE_I) begin
      d.loc_temp = LOCAL_RESULT_I;
      d.rem_temp = rem_store;
    end
    // open-sensor comparator: three stages, change accepted when last two agree
    d.open_sync = {q.open_sync[1:0], REMOTE_OPEN_PIN_I};
    if (q.open_sync[1] == q.open_sync[2]) begin
      d.open_filt = q.open_sync[2];
    end
    if (CONV_START_I) begin
      d.open_flag = q.open_filt;
    end
    // alarm evaluation
    d.loc_low_hit = low_hit[0];
    d.rem_low_hit = low_hit[1];
    d.loc_high_hit = high_hit[0];
    d.rem_high_hit = high_hit[1];
    alert_cond = (|low_hit) | (|high_hit) | q.open_flag;
    // a live cause wins over the acknowledge
    d.alert_pend = alert_cond | (q.alert_pend & ~ALERT_ACK_I);
    d.alert_oe_n = ~(q.alert_pend & ~q.cfg[temp_alarm_pkg::CFG_MASK_BIT]);
    d.crit_oe_n = ~(|crit_hit);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.hready <= 1'b1;
      q.cfg <= temp_alarm_pkg::CONFIG_RST;
      q.loc_temp <= temp_alarm_pkg::TEMP_RST;
      q.rem_temp <= temp_alarm_pkg::TEMP_RST;
      q.loc_high <= temp_alarm_pkg::HIGH_RST;
      q.rem_high <= temp_alarm_pkg::HIGH_RST;
      q.loc_low <= temp_alarm_pkg::LOW_RST;
      q.rem_low <= temp_alarm_pkg::LOW_RST;
      q.loc_crit <= temp_alarm_pkg::CRIT_RST;
      q.rem_crit <= temp_alarm_pkg::CRIT_RST;
      q.hyst <= temp_alarm_pkg::HYST_RST;
      q.offset <= temp_alarm_pkg::OFFSET_RST;
      q.alert_oe_n <= 1'b1;
      q.crit_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign HRDATA_O = q.hrdata;
  assign HREADYOUT_O = q.hready;
  assign HRESP_O = q.hresp;
  assign STANDBY_O = q.cfg[temp_alarm_pkg::CFG_STANDBY_BIT];
  assign ALERT_OUT_O = q.hresp;
  assign ALERT_OE_N_O = q.alert_oe_n;
  assign CRITICAL_OUT_N_O = q.hresp;
  assign CRITICAL_OE_N_O = q.crit_oe_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  low_alarm_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    ($signed(q.rem_temp) <= $signed(q.rem_low)) |=> q.alert_pend && q.rem_low_hit)
    else $error("low limit hit did not raise the alarm");

  high_alarm_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    ($signed(q.loc_temp) > $signed(q.loc_high) && !q.cfg[temp_alarm_pkg::CFG_MASK_BIT])
    |=> ##1 (!ALERT_OE_N_O || $past(q.cfg[temp_alarm_pkg::CFG_MASK_BIT])))
    else $error("high limit hit did not drive the alarm pin");

  quiet_alarm_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (!alert_cond && !q.alert_pend) |=> !q.alert_pend ##1 ALERT_OE_N_O)
    else $error("alarm raised with all readings in range");

  crit_pin_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (|crit_hit) |=> !CRITICAL_OE_N_O)
    else $error("critical pin not driven while a channel is critical");

  mask_alarm_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    q.cfg[temp_alarm_pkg::CFG_MASK_BIT] |=> ALERT_OE_N_O)
    else $error("masked alarm still drove the pin");

  hyst_default_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    $rose(rst_n) |-> (q.hyst == temp_alarm_pkg::HYST_RST)
    && (q.loc_low == temp_alarm_pkg::LOW_RST) && (q.rem_low == temp_alarm_pkg::LOW_RST))
    else $error("hysteresis or low limit wrong after reset");

  open_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (CONV_START_I && q.open_filt) |=> q.open_flag ##1 q.alert_pend)
    else $error("open sensor at conversion start not flagged");

  short_code_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (CONV_DONE_I && REMOTE_UNDER_I) |=> (q.rem_temp == temp_alarm_pkg::SHORT_CODE) ##1 q.alert_pend)
    else $error("shorted remote sensor not stored as minus 128 with alarm");

  offset_add_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (CONV_DONE_I && !REMOTE_UNDER_I && (rem_sum[8] == rem_sum[7]))
    |=> (q.rem_temp == $past(REMOTE_RESULT_I) + $past(q.offset)))
    else $error("remote offset not added to the stored reading");

  ack_release_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (ALERT_ACK_I && !alert_cond) |=> !q.alert_pend)
    else $error("alert not released after response with cause gone");

  ack_keep_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (ALERT_ACK_I && alert_cond) |=> q.alert_pend)
    else $error("alert released while its cause persists");

  open_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (CONV_START_I && !q.open_filt) |=> !q.open_flag)
    else $error("closed sensor at conversion start left the open flag set");

  open_alarm_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    q.open_flag |=> q.alert_pend)
    else $error("open remote sensor did not raise the alarm");

  limit_alarm_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    ((|low_hit) || (|high_hit)) |=> q.alert_pend)
    else $error("limit hit on stored readings did not raise the alarm");

  crit_unmasked_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    ((|crit_hit) && q.cfg[temp_alarm_pkg::CFG_MASK_BIT]) |=> !CRITICAL_OE_N_O)
    else $error("alarm mask suppressed the critical pin");

  hyst_write_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (q.wr_pend && (q.addr == temp_alarm_pkg::OFS_CRIT_HYST))
    |=> (q.hyst == $past(HWDATA_I[7:0])))
    else $error("hysteresis write not stored as eight-bit binary");

endmodule // temp_limit_alarm

// File: alarm_host_model.sv
// host-side model: pulled-up alarm lines and alert response service
`timescale 1ns/100ps
module alarm_host_model (
  // clock
  input wire logic clk_i,
  // open-drain pins of the device
  input wire logic alert_out_i,
  input wire logic alert_oe_n_i,
  input wire logic crit_out_i,
  input wire logic crit_oe_n_i,
  // bench request to service the alert line
  input wire logic service_i,
  // resolved lines and handshake
  output logic alert_line_o,
  output logic crit_line_o,
  output logic alert_ack_o
);
  // a released pin leaves the line to its pull-up
  assign alert_line_o = alert_oe_n_i ? 1'b1 : alert_out_i;
  assign crit_line_o = crit_oe_n_i ? 1'b1 : crit_out_i;
  // the alert response is only answered while the line is held low
  always @(posedge clk_i) begin
    alert_ack_o <= service_i && (alert_line_o === 1'b0);
  end
endmodule // alarm_host_model

// File: temp_limit_alarm_tb.sv
// self-checking testbench of the temperature limit alarm block
`timescale 1ns/100ps
module temp_limit_alarm_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic conv_start = 1'b0;
  logic conv_done = 1'b0;
  logic [7:0] local_res = 8'h00;
  logic [7:0] remote_res = 8'h00;
  logic remote_under = 1'b0;
  logic remote_open = 1'b0;
  logic standby;
  logic alert_ack;
  logic alert_out;
  logic alert_oe_n;
  logic crit_out;
  logic crit_oe_n;
  logic service = 1'b0;
  logic alert_line;
  logic crit_line;
  logic [31:0] v;
  int miscompares = 0;
  int samples_checked = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  temp_limit_alarm u_dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
    .CONV_START_I(conv_start), .CONV_DONE_I(conv_done), .LOCAL_RESULT_I(local_res),
    .REMOTE_RESULT_I(remote_res), .REMOTE_UNDER_I(remote_under),
    .REMOTE_OPEN_PIN_I(remote_open), .STANDBY_O(standby), .ALERT_ACK_I(alert_ack),
    .ALERT_OUT_O(alert_out), .ALERT_OE_N_O(alert_oe_n), .CRITICAL_OUT_N_O(crit_out),
    .CRITICAL_OE_N_O(crit_oe_n));

  alarm_host_model u_host (.clk_i(clk), .alert_out_i(alert_out), .alert_oe_n_i(alert_oe_n),
    .crit_out_i(crit_out), .crit_oe_n_i(crit_oe_n), .service_i(service),
    .alert_line_o(alert_line), .crit_line_o(crit_line), .alert_ack_o(alert_ack));

  // ----------------------------------------------------------------
  // bus, conversion and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, {24'h0, d}, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask

  task automatic conv(input logic [7:0] loc, input logic [7:0] rem, input logic under);
    @(posedge clk);
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
    conv_done <= 1'b1;
    local_res <= loc;
    remote_res <= rem;
    remote_under <= under;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic svc();
    @(posedge clk);
    service <= 1'b1;
    @(posedge clk);
    service <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(temp_alarm_pkg::OFS_CRIT_HYST, v);
    chk(v, 32'h0a);
    rd(temp_alarm_pkg::OFS_LOCAL_LOW, v);
    chk(v, 32'h00);
    rd(8'h40, v);
    chk({v[31:1], hresp}, 32'h0);
    chk({31'h0, alert_line}, 32'h0);
    wr(temp_alarm_pkg::OFS_LOCAL_LOW, 8'he0);
    wr(temp_alarm_pkg::OFS_REMOTE_LOW, 8'he0);
    conv(8'h19, 8'h1e, 1'b0);
    svc();
    chk({31'h0, alert_line}, 32'h1);
    rd(temp_alarm_pkg::OFS_STATUS, v);
    chk(v & 32'h78, 32'h00);
    conv(8'he0, 8'h1e, 1'b0);
    chk({31'h0, alert_line}, 32'h0);
    rd(temp_alarm_pkg::OFS_STATUS, v);
    chk(v & 32'h78, 32'h20);
    conv(8'h19, 8'h56, 1'b0);
    rd(temp_alarm_pkg::OFS_STATUS, v);
    chk(v & 32'h78, 32'h10);
    conv(8'h19, 8'h55, 1'b0);
    svc();
    chk({31'h0, alert_line}, 32'h1);
    // masked alarm, unmaskable critical pin
    wr(temp_alarm_pkg::OFS_CONFIG, 8'h80);
    conv(8'h19, 8'h60, 1'b0);
    chk({31'h0, alert_line}, 32'h1);
    chk({31'h0, crit_line}, 32'h0);
    rd(temp_alarm_pkg::OFS_STATUS, v);
    chk(v & 32'h83, 32'h82);
    conv(8'h19, 8'h4c, 1'b0);
    chk({31'h0, crit_line}, 32'h0);
    conv(8'h19, 8'h4b, 1'b0);
    chk({31'h0, crit_line}, 32'h1);
    wr(temp_alarm_pkg::OFS_CONFIG, 8'h00);
    svc();
    // local critical with one degree of hysteresis
    wr(temp_alarm_pkg::OFS_CRIT_HYST, 8'h01);
    wr(temp_alarm_pkg::OFS_LOCAL_HIGH, 8'h30);
    wr(temp_alarm_pkg::OFS_LOCAL_CRIT, 8'h30);
    conv(8'h31, 8'h19, 1'b0);
    chk({31'h0, crit_line}, 32'h0);
    conv(8'h30, 8'h19, 1'b0);
    chk({31'h0, crit_line}, 32'h0);
    conv(8'h2f, 8'h19, 1'b0);
    chk({31'h0, crit_line}, 32'h1);
    // signed remote offset, read-only reading
    wr(temp_alarm_pkg::OFS_REMOTE_OFFSET, 8'h05);
    conv(8'h19, 8'h14, 1'b0);
    rd(temp_alarm_pkg::OFS_REMOTE_TEMP, v);
    chk(v, 32'h19);
    wr(temp_alarm_pkg::OFS_REMOTE_OFFSET, 8'hfb);
    conv(8'h19, 8'h14, 1'b0);
    rd(temp_alarm_pkg::OFS_REMOTE_TEMP, v);
    chk(v, 32'h0f);
    wr(temp_alarm_pkg::OFS_LOCAL_TEMP, 8'h55);
    rd(temp_alarm_pkg::OFS_LOCAL_TEMP, v);
    chk(v, 32'h19);
    svc();
    chk({31'h0, alert_line}, 32'h1);
    // shorted remote sensor against the lowest low limit
    wr(temp_alarm_pkg::OFS_REMOTE_LOW, 8'h80);
    conv(8'h19, 8'h00, 1'b1);
    rd(temp_alarm_pkg::OFS_REMOTE_TEMP, v);
    chk(v, 32'h80);
    chk({31'h0, alert_line}, 32'h0);
    rd(temp_alarm_pkg::OFS_STATUS, v);
    chk(v & 32'h08, 32'h08);
    conv(8'h19, 8'h14, 1'b0);
    svc();
    // open remote sensor
    remote_open <= 1'b1;
    repeat (8) @(posedge clk);
    conv(8'h19, 8'h14, 1'b0);
    rd(temp_alarm_pkg::OFS_STATUS, v);
    chk(v & 32'h04, 32'h04);
    chk({31'h0, alert_line}, 32'h0);
    remote_open <= 1'b0;
    repeat (8) @(posedge clk);
    conv(8'h19, 8'h14, 1'b0);
    svc();
    rd(temp_alarm_pkg::OFS_STATUS, v);
    chk(v & 32'h04, 32'h00);
    chk({31'h0, alert_line}, 32'h1);
    // limit write in standby
    wr(temp_alarm_pkg::OFS_CONFIG, 8'h40);
    @(posedge clk);
    chk({31'h0, standby}, 32'h1);
    wr(temp_alarm_pkg::OFS_LOCAL_HIGH, 8'h10);
    repeat (4) @(posedge clk);
    chk({31'h0, alert_line}, 32'h0);
    tally_and_finish();
  end

  initial begin
    #40000;
    miscompares++;
    tally_and_finish();
  end
endmodule // temp_limit_alarm_tb
